// ==== rtl/ewsg_pkg.sv ====
// Purpose : shared constants and types of the external wait-state generator
// Assumes : 32-bit APB, registers on word-aligned byte addresses
// Notes   : register byte address is four times its index
package ewsg_pkg;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam logic [7:0]  EWSG_CFG_IDX     = 8'h28;
   localparam logic [7:0]  EWSG_CTRL_IDX    = 8'h2B;
   localparam logic [9:0]  EWSG_CFG_ADDR    = {EWSG_CFG_IDX, 2'b00};
   localparam logic [9:0]  EWSG_CTRL_ADDR   = {EWSG_CTRL_IDX, 2'b00};

   // ----------------------------------------------------------------------
   // field layout of wait_count_config_reg
   // ----------------------------------------------------------------------
   localparam int          EWSG_PLO_LSB     = 0;
   localparam int          EWSG_PHI_LSB     = 3;
   localparam int          EWSG_DLO_LSB     = 6;
   localparam int          EWSG_DHI_LSB     = 9;
   localparam int          EWSG_IO_LSB      = 12;
   localparam int          EWSG_XPR_BIT     = 15;
   localparam int          EWSG_FIELD_W     = 3;
   localparam int          EWSG_DBL_BIT     = 0;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [15:0] EWSG_CFG_RST     = 16'h7FFF;
   localparam logic        EWSG_DBL_RST     = 1'b0;

   // ----------------------------------------------------------------------
   // address decode points
   // ----------------------------------------------------------------------
   localparam int          EWSG_PAGE_HALF_BIT = 15;
   localparam int          EWSG_EXT_HALF_BIT  = 22;
   localparam int          EWSG_PADDR_W       = 23;

   typedef enum logic [1:0] {
      EWSG_SPACE_PROG,
      EWSG_SPACE_DATA,
      EWSG_SPACE_IO
   } ewsg_space_t;

   typedef struct packed {
      ewsg_space_t               space;
      logic [EWSG_PADDR_W-1:0]   addr;
   } ewsg_acc_t;

endpackage : ewsg_pkg

// ==== rtl/ewsg_top.sv ====
// Purpose : stretches external program, data and I/O accesses by a
//           programmable number of machine cycles chosen per address range
// Assumes : one clock pclk; ext_ready arrives from a pin
// Notes   : registers reached over APB
//
// Behaviour
// - Stretch each external access by software count, at most fourteen waits.
// - Beyond the count, keep waiting until the external ready line is high.
// - All range fields zero turns the generator clock enable off.
// - Low config bits hold five independent 3-bit base counts, 0 to 7.
// - After reset every range field is 111, seven waits everywhere.
// - Config bit 15, reset 0, selects program-space range decoding.
// - Bits 14..12 give the base count for all I/O accesses.
// - Bits 11..9 give the base count for upper half data space.
// - Bits 8..6 give the base count for lower half data space.
// - Bits 5..3 cover upper program: page upper half, or 400000h-7FFFFFh.
// - Bits 2..0 cover lower program: page lower half, or 000000h-3FFFFFh.
// - Multiplier bit set doubles every base count, up to fourteen waits.
// - Multiplier bit clear, its reset value, uses base counts unchanged.
// - Control register bits 31..1 read zero and ignore writes.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module ewsg_top
   import ewsg_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              acc_req,
   input  wire ewsg_acc_t         acc,
   input  wire logic              ext_ready,
   output logic                   acc_busy,
   output logic                   acc_done,
   output logic                   wsg_clk_en
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      EWSG_IDLE,
      EWSG_COUNT,
      EWSG_HOLD
   } ewsg_state_t;

   ewsg_state_t state_q;
   ewsg_state_t state_d;
   logic [15:0] cfg_q;
   logic        dbl_q;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_d;
   logic        ready_m_q;
   logic        ready_s_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        busy_q;
   logic        done_q;
   logic        clk_en_q;

   wire         setup_ph  = psel & ~penable;
   wire         access_ph = psel & penable & pready_q;
   wire         hit_cfg   = (paddr == ADDR_W'(EWSG_CFG_ADDR));
   wire         hit_ctrl  = (paddr == ADDR_W'(EWSG_CTRL_ADDR));
   wire         wr_cfg    = access_ph & pwrite & hit_cfg;
   wire         wr_ctrl   = access_ph & pwrite & hit_ctrl;

   wire [31:0]  rd_mux    = hit_cfg  ? {16'h0000, cfg_q} :
                            hit_ctrl ? {31'h00000000, dbl_q} : 32'h00000000;

   // ----------------------------------------------------------------------
   // range decode
   // ----------------------------------------------------------------------
   // five fields
   wire [2:0] f_plo = cfg_q[EWSG_PLO_LSB +: EWSG_FIELD_W];
   wire [2:0] f_phi = cfg_q[EWSG_PHI_LSB +: EWSG_FIELD_W];
   wire [2:0] f_dlo = cfg_q[EWSG_DLO_LSB +: EWSG_FIELD_W];
   wire [2:0] f_dhi = cfg_q[EWSG_DHI_LSB +: EWSG_FIELD_W];
   wire [2:0] f_io  = cfg_q[EWSG_IO_LSB +: EWSG_FIELD_W];
   wire       xpr   = cfg_q[EWSG_XPR_BIT];

   wire       prog_hi = xpr ? acc.addr[EWSG_EXT_HALF_BIT] : acc.addr[EWSG_PAGE_HALF_BIT];
   wire [2:0] prog_w  = prog_hi ? f_phi : f_plo;
   wire [2:0] data_w  = acc.addr[EWSG_PAGE_HALF_BIT] ? f_dhi : f_dlo;
   wire [2:0] base_w  = (acc.space == EWSG_SPACE_IO)   ? f_io   :
                        (acc.space == EWSG_SPACE_DATA) ? data_w : prog_w;
   wire [3:0] wait_w  = dbl_q ? {base_w, 1'b0} : {1'b0, base_w};

   // ----------------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------------
   wire start = (state_q == EWSG_IDLE) & acc_req;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         EWSG_IDLE: begin
            if (acc_req) begin
               cnt_d   = wait_w;
               state_d = (wait_w == 4'h0) ? EWSG_HOLD : EWSG_COUNT;
            end
         end
         EWSG_COUNT: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               state_d = EWSG_HOLD;
            end
         end
         EWSG_HOLD: begin
            if (ready_s_q) begin
               state_d = EWSG_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= EWSG_IDLE;
         cnt_q   <= 4'h0;
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         busy_q  <= (state_d != EWSG_IDLE);
         done_q  <= (state_q == EWSG_HOLD) & ready_s_q;
      end
   end

   // ready pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_m_q <= 1'b0;
         ready_s_q <= 1'b0;
      end else begin
         ready_m_q <= ext_ready;
         ready_s_q <= ready_m_q;
      end
   end

   // ----------------------------------------------------------------------
   // registers and APB slave
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= EWSG_CFG_RST;
         dbl_q <= EWSG_DBL_RST;
      end else begin
         if (wr_cfg) begin
            cfg_q <= pwdata[15:0];
         end
         if (wr_ctrl) begin
            dbl_q <= pwdata[EWSG_DBL_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup_ph;
         if (setup_ph) begin
            prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= ~(hit_cfg | hit_ctrl);
         end else if (access_ph) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_en_q <= 1'b1;
      end else begin
         clk_en_q <= |cfg_q[EWSG_XPR_BIT-1:0];
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign acc_busy   = busy_q;
   assign acc_done   = done_q;
   assign wsg_clk_en = clk_en_q;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   logic [4:0] lat_q;
   logic [3:0] lat_w_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_q   <= 5'h00;
         lat_w_q <= 4'h0;
      end else if (start) begin
         lat_q   <= 5'h01;
         lat_w_q <= wait_w;
      end else if (state_q != EWSG_IDLE && lat_q != 5'h1F) begin
         lat_q   <= lat_q + 5'h01;
      end
   end

   default clocking ewsg_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_wait_max_fourteen: assert property (cnt_q <= 4'hE)
      else $error("wait count above fourteen");

   a_latency_least: assert property (
      acc_done |-> lat_q >= {1'b0, lat_w_q} + 5'h01)
      else $error("access finished before its wait count");

   a_hold_no_ready: assert property (
      (state_q == EWSG_HOLD && !ready_s_q) |=> !acc_done && acc_busy)
      else $error("access completed without ready");

   a_clock_gate: assert property (
      ##1 wsg_clk_en == (|$past(cfg_q[14:0])))
      else $error("clock enable disagrees with fields");

   // ----------------------------------------------------------------------
   // range selection checks
   // ----------------------------------------------------------------------
   a_io_count: assert property (
      (start && acc.space == EWSG_SPACE_IO && !dbl_q)
         |=> cnt_q == {1'b0, $past(cfg_q[14:12])})
      else $error("io count not loaded");

   a_double_count: assert property (
      (start && dbl_q && acc.space == EWSG_SPACE_DATA && !acc.addr[15])
         |=> cnt_q == {$past(cfg_q[8:6]), 1'b0})
      else $error("doubled count wrong");

   a_prog_ext_hi: assert property (
      (start && acc.space == EWSG_SPACE_PROG && cfg_q[15] && acc.addr[22] && !dbl_q)
         |=> cnt_q == {1'b0, $past(cfg_q[5:3])})
      else $error("extended upper program count wrong");

   a_data_hi_count: assert property (
      (start && acc.space == EWSG_SPACE_DATA && acc.addr[15] && !dbl_q)
         |=> cnt_q == {1'b0, $past(cfg_q[11:9])})
      else $error("upper data count wrong");

   a_data_lo_count: assert property (
      (start && acc.space == EWSG_SPACE_DATA && !acc.addr[15] && !dbl_q)
         |=> cnt_q == {1'b0, $past(cfg_q[8:6])})
      else $error("lower data count wrong");

   a_prog_page_hi: assert property (
      (start && acc.space == EWSG_SPACE_PROG && !cfg_q[15] && acc.addr[15] && !dbl_q)
         |=> cnt_q == {1'b0, $past(cfg_q[5:3])})
      else $error("upper page program count wrong");

   a_prog_page_lo: assert property (
      (start && acc.space == EWSG_SPACE_PROG && !cfg_q[15] && !acc.addr[15] && !dbl_q)
         |=> cnt_q == {1'b0, $past(cfg_q[2:0])})
      else $error("lower page program count wrong");

   a_prog_ext_lo: assert property (
      (start && acc.space == EWSG_SPACE_PROG && cfg_q[15] && !acc.addr[22] && !dbl_q)
         |=> cnt_q == {1'b0, $past(cfg_q[2:0])})
      else $error("extended lower program count wrong");

   a_io_double: assert property (
      (start && acc.space == EWSG_SPACE_IO && dbl_q)
         |=> cnt_q == {$past(cfg_q[14:12]), 1'b0})
      else $error("doubled io count wrong");

   a_double_even: assert property ((start && dbl_q) |=> !cnt_q[0])
      else $error("doubled count is odd");

   a_ctrl_read_zero: assert property (
      (access_ph && !pwrite && hit_ctrl) |-> prdata[31:1] == 31'h00000000)
      else $error("control upper bits not zero");

   a_done_single: assert property (acc_done |=> !acc_done)
      else $error("done longer than one cycle");

   a_pready_one: assert property (pready |=> !pready)
      else $error("pready held too long");

   a_cfg_store: assert property (
      wr_cfg |=> cfg_q == $past(pwdata[15:0]))
      else $error("config write not stored");

   a_ctrl_store: assert property (
      wr_ctrl |=> dbl_q == $past(pwdata[0]))
      else $error("multiplier write not stored");

   a_zero_skip: assert property (
      (start && wait_w == 4'h0) |=> state_q == EWSG_HOLD)
      else $error("zero count did not skip counting");

   a_count_down: assert property (
      (state_q == EWSG_COUNT && cnt_q != 4'h1) |=> cnt_q == $past(cnt_q) - 4'h1)
      else $error("wait count did not step down");

   a_ready_done: assert property (
      (state_q == EWSG_HOLD && ready_s_q) |=> acc_done && !acc_busy)
      else $error("ready seen but access not finished");

   a_busy_done: assert property (acc_done |-> !acc_busy)
      else $error("busy still high at done");

   a_idle_quiet: assert property (
      (state_q == EWSG_IDLE && !acc_req) |=> !acc_busy && !acc_done)
      else $error("idle sequencer reported activity");

   // ----------------------------------------------------------------------
   // cover points
   // ----------------------------------------------------------------------
   c_zero_wait: cover property (start && wait_w == 4'h0 ##[1:4] acc_done);
   c_fourteen:  cover property (start && wait_w == 4'hE ##[15:40] acc_done);
   c_ready_stall: cover property ((state_q == EWSG_HOLD && !ready_s_q)[*3] ##1 acc_done);
   c_cfg_write: cover property (wr_cfg ##1 !wsg_clk_en);
   c_doubled:   cover property (start && dbl_q ##1 state_q == EWSG_COUNT);

endmodule : ewsg_top

// ==== verification/ewsg_ext_dev.sv ====
// Purpose : external device model that can stretch an access with its ready line
// Assumes : stall is the number of cycles ready stays low once an access starts
// Notes   : stall of zero answers promptly
`timescale 1ns/1ps
module ewsg_ext_dev
   import ewsg_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       acc_busy,
   input  wire logic [3:0] stall,
   output logic            ext_ready
);
   logic       busy_q;
   logic [3:0] cnt_q;
   assign ext_ready = (cnt_q == 4'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cnt_q  <= 4'h0;
      end else begin
         busy_q <= acc_busy;
         if (acc_busy && !busy_q) begin
            cnt_q <= stall;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule : ewsg_ext_dev

// ==== verification/tb_ewsg_top.sv ====
// Purpose : self-checking bench of the wait-state generator
// Assumes : APB slave answers after its own handshake; device model on ready
// Notes   : access length is counted from the taking edge to acc_done
`timescale 1ns/1ps
module tb_ewsg_top;
   import ewsg_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic acc_req, ext_ready, acc_busy, acc_done, wsg_clk_en, er;
   logic [3:0] stall;
   ewsg_acc_t acc;
   ewsg_space_t sp [6] = '{EWSG_SPACE_IO, EWSG_SPACE_DATA, EWSG_SPACE_DATA,
                          EWSG_SPACE_PROG, EWSG_SPACE_PROG, EWSG_SPACE_PROG};
   logic [22:0] ad [6] = '{23'h7FFFFF, 23'h008000, 23'h007FFF, 23'h008000,
                           23'h400000, 23'h7F7FFF};
   int base [6] = '{1, 2, 3, 4, 5, 5};
   int bad_count = 0;
   int cmp_count = 0;
   ewsg_top #(.ADDR_W(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .acc_req(acc_req), .acc(acc), .ext_ready(ext_ready),
      .acc_busy(acc_busy), .acc_done(acc_done), .wsg_clk_en(wsg_clk_en));
   ewsg_ext_dev i_dev (.pclk(pclk), .presetn(presetn), .acc_busy(acc_busy), .stall(stall),
      .ext_ready(ext_ready));
   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : cmp
   task automatic apb(logic wr, logic [9:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic acc_run(ewsg_space_t sp, logic [22:0] a, int n, int extra);
      int c;
      acc_req <= 1'b1;
      acc <= '{space: sp, addr: a};
      @(posedge pclk);
      acc_req <= 1'b0;
      for (c = 1; c < 60; c++) begin
         @(posedge pclk);
         #1;
         if (c == 1) begin
            cmp("busy after take", 32'(n + extra > 0), 32'(acc_busy));
         end
         if (acc_done === 1'b1) begin
            break;
         end
      end
      cmp("access length", 32'(n + 1 + extra), 32'(c));
      cmp("busy at done", 32'h0, 32'(acc_busy));
      @(posedge pclk);
   endtask : acc_run
   // ----------------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      #(40 * 6000);
      bad_count++;
      finish_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, acc_req} = 5'h00;
      {paddr, pwdata, acc, stall} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, EWSG_CFG_ADDR, 32'h0);
      cmp("cfg reset", 32'h00007FFF, rd);
      apb(1'b0, EWSG_CTRL_ADDR, 32'h0);
      cmp("ctrl reset", 32'h00000000, rd);
      apb(1'b0, 10'h0A4, 32'h0);
      cmp("unmapped err", 32'h1, 32'(er));
      acc_run(EWSG_SPACE_PROG, 23'h000000, 7, 1'b0);
      apb(1'b1, EWSG_CTRL_ADDR, 32'hFFFFFFFF);
      apb(1'b0, EWSG_CTRL_ADDR, 32'h0);
      cmp("ctrl readback", 32'h00000001, rd);
      acc_run(EWSG_SPACE_IO, 23'h000000, 14, 1'b0);
      apb(1'b1, EWSG_CFG_ADDR, 32'h000014E5);
      apb(1'b0, EWSG_CFG_ADDR, 32'h0);
      cmp("cfg readback", 32'h000014E5, rd);
      for (int m = 1; m >= 0; m--) begin
         apb(1'b1, EWSG_CTRL_ADDR, 32'(m));
         for (int i = 0; i < 6; i++) begin
            acc_run(sp[i], ad[i], base[i] << m, 1'b0);
         end
      end
      apb(1'b1, EWSG_CFG_ADDR, 32'h000094E5);
      acc_run(EWSG_SPACE_PROG, 23'h400000, 4, 1'b0);
      acc_run(EWSG_SPACE_PROG, 23'h3F8000, 5, 1'b0);
      stall <= 4'hA;
      acc_run(EWSG_SPACE_DATA, 23'h000000, 3, 10);
      stall <= 4'h0;
      apb(1'b1, EWSG_CFG_ADDR, 32'h00008000);
      repeat (2) @(posedge pclk);
      cmp("clock enable off", 32'h0, 32'(wsg_clk_en));
      acc_run(EWSG_SPACE_IO, 23'h000000, 0, 1'b0);
      apb(1'b1, EWSG_CFG_ADDR, 32'h00000001);
      repeat (2) @(posedge pclk);
      cmp("clock enable on", 32'h1, 32'(wsg_clk_en));
      apb(1'b1, EWSG_CTRL_ADDR, 32'h00000001);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, EWSG_CFG_ADDR, 32'h0);
      cmp("cfg after reset", 32'h00007FFF, rd);
      apb(1'b0, EWSG_CTRL_ADDR, 32'h0);
      cmp("ctrl after reset", 32'h00000000, rd);
      acc_run(EWSG_SPACE_DATA, 23'h008000, 7, 0);
      finish_test();
   end
endmodule : tb_ewsg_top
